// file: logic/csp_port.sv
// Codec audio serial port: sample FIFO, register file and bit clock link logic.
`timescale 1ns/100ps

// Sample FIFO with valid and ready on both sides
module csp_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	// Whole FIFO state
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} csp_fifo_t;
	csp_fifo_t st_r; // Registered state
	csp_fifo_t st_nxt; // Next state
	logic push; // Word taken in
	logic pop; // Word handed out

	// Handshakes, storage and pointers
	always_comb begin
		st_nxt = st_r;
		in_ready = (st_r.cnt != FULL);
		out_valid = (st_r.cnt != '0);
		out_data = st_r.mem[st_r.rp];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (!rst_n) begin
			st_nxt = '0;
		end else if (ce) begin
			if (push) begin
				st_nxt.mem[st_r.wp] = in_data;
				st_nxt.wp = (st_r.wp == LAST) ? '0 : st_r.wp + 1'b1;
			end
			if (pop) begin
				st_nxt.rp = (st_r.rp == LAST) ? '0 : st_r.rp + 1'b1;
			end
			st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	// State register
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end
endmodule

// Serial port top
module csp_port (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [6:0] REG_ADDR,
	input wire logic [8:0] REG_WDATA,
	output logic [8:0] REG_RDATA,
	input wire logic ADC_VALID,
	output logic ADC_READY,
	input wire csp_pkg::csp_pair_t ADC_DATA,
	output logic DAC_VALID,
	input wire logic DAC_READY,
	output csp_pkg::csp_pair_t DAC_DATA,
	input wire logic BIT_CLK_I,
	output logic BIT_CLK_O,
	output logic BIT_CLK_OE,
	input wire logic FRAME_SYNC_I,
	output logic FRAME_SYNC_O,
	output logic FRAME_SYNC_OE,
	input wire logic DAC_SERIAL_IN,
	output logic ADC_SERIAL_OUT_O,
	output logic ADC_SERIAL_OUT_OE,
	output logic ADC_PULL_UP,
	output logic ADC_PULL_DOWN
);
	localparam logic [10:0] W11 = 11'(csp_pkg::SAMPLE_W);
	localparam logic [4:0] TOPBIT = 5'(csp_pkg::SAMPLE_W - 1);
	localparam logic [5:0] MHALF = 6'(csp_pkg::MASTER_HALF);
	localparam logic [5:0] MLAST = 6'(2 * csp_pkg::MASTER_HALF - 1);
	localparam logic [2:0] BDIV_LAST = 3'(csp_pkg::BCLK_HALF_CYC - 1);

	// Master clock domain state
	typedef struct packed {
		logic [8:0] fmt;
		logic [8:0] role;
		logic [8:0] ldly;
		logic [8:0] slot;
		logic [8:0] rdly;
		logic [8:0] rdata;
		csp_pkg::csp_cfg_t cfg_sent;
		logic creq;
		logic cack1;
		logic cack2;
		csp_pkg::csp_pair_t adc_hold;
		logic areq;
		logic aack1;
		logic aack2;
		logic rtog1;
		logic rtog2;
		logic rtog3;
		csp_pkg::csp_pair_t dac;
		logic dac_vld;
		logic [2:0] bdiv;
		logic bclk;
	} csp_ms_t;
	// Link rising edge state
	typedef struct packed {
		logic rst1;
		logic rst;
		logic ce1;
		logic ce;
		logic creq1;
		logic creq2;
		logic cack;
		csp_pkg::csp_cfg_t cfg;
		logic areq1;
		logic areq2;
		logic aack;
		csp_pkg::csp_pair_t tx;
		logic fs_prev;
		logic [10:0] pos;
		logic [10:0] len;
		csp_pkg::csp_pair_t rx;
		csp_pkg::csp_pair_t rx_hold;
		logic rtog;
		logic nbit;
		logic nact;
		logic hold;
	} csp_lp_t;
	// Link falling edge state
	typedef struct packed {
		logic [5:0] mcnt;
		logic fs_o;
		logic dout;
		logic oe;
	} csp_ln_t;

	localparam csp_ms_t MS_RST = '{fmt: csp_pkg::FMT_RST, role: csp_pkg::ROLE_RST,
		ldly: csp_pkg::DLY_RST, slot: csp_pkg::SLOT_RST, rdly: csp_pkg::DLY_RST,
		cfg_sent: csp_pkg::CFG_RST, default: '0};
	localparam csp_lp_t LP_RST = '{cfg: csp_pkg::CFG_RST, default: '0};

	csp_ms_t ms_r; // Master domain registers
	csp_ms_t ms_nxt; // Master domain next
	csp_lp_t lp_r; // Link rising edge registers
	csp_lp_t lp_nxt; // Link rising edge next
	csp_ln_t ln_r; // Link falling edge registers
	csp_ln_t ln_nxt; // Link falling edge next
	csp_pkg::csp_cfg_t cfg_now; // Configuration from registers
	logic fifo_vld; // FIFO holds a pair
	logic fifo_pop; // Pair moved to the crossing
	logic [2*csp_pkg::SAMPLE_W-1:0] fifo_dat; // FIFO head

	// Pulse and slot framings count from a sync rise
	function automatic logic is_frame(input csp_pkg::csp_mode_t m);
		is_frame = (m == csp_pkg::MD_PCMA) || (m == csp_pkg::MD_PCMB) || (m == csp_pkg::MD_TSLOT);
	endfunction

	// Edge q lies within a slot starting at s
	function automatic logic in_slot(input logic [10:0] q, input logic [10:0] s);
		in_slot = (q >= s) && ((q - s) < W11);
	endfunction

	// Channel and bit index carried on edge q
	function automatic csp_pkg::csp_slot_t slot_at(input logic [10:0] q, input logic [10:0] len,
		input logic fs, input csp_pkg::csp_cfg_t c);
		logic [10:0] off;
		logic [10:0] sl;
		logic [10:0] sr;
		csp_pkg::csp_slot_t r;
		off = '0;
		sl = '0;
		sr = '0;
		r = '0;
		unique case (c.mode)
			csp_pkg::MD_LJ: off = 11'h001;
			csp_pkg::MD_I2S: off = 11'h002;
			csp_pkg::MD_RJ: off = (len > W11) ? len - W11 + 11'h001 : 11'h001;
			csp_pkg::MD_PCMA: begin
				sl = 11'h002;
				sr = 11'h002 + W11;
			end
			csp_pkg::MD_PCMB: begin
				sl = 11'h001;
				sr = 11'h001 + W11;
			end
			csp_pkg::MD_TSLOT: begin
				sl = {1'b0, c.ldly} + 11'h001;
				sr = {1'b0, c.rdly} + 11'h001;
			end
			default: off = 11'h001;
		endcase
		if (off != '0) begin
			// Half frame framings: channel from sync level
			r.act = in_slot(q, off);
			r.right = (c.mode == csp_pkg::MD_I2S) ? fs : ~fs;
			r.idx = 5'(q - off);
		end else if (in_slot(q, sl)) begin
			r.act = 1'b1;
			r.right = 1'b0;
			r.idx = 5'(q - sl);
		end else if (in_slot(q, sr)) begin
			r.act = 1'b1;
			r.right = 1'b1;
			r.idx = 5'(q - sr);
		end
		return r;
	endfunction

	// ADC pairs queue here until the link takes them
	csp_fifo #(
		.WIDTH(2 * csp_pkg::SAMPLE_W),
		.DEPTH(csp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(MCLK),
		.rst_n(RST_N),
		.ce(CE),
		.in_valid(ADC_VALID),
		.in_ready(ADC_READY),
		.in_data(ADC_DATA),
		.out_valid(fifo_vld),
		.out_ready(fifo_pop),
		.out_data(fifo_dat)
	);

	// Configuration decoded from the register file
	always_comb begin
		cfg_now = csp_pkg::CFG_RST;
		cfg_now.master = ms_r.role[csp_pkg::ROLE_BIT];
		cfg_now.tri_neg = ms_r.slot[csp_pkg::TRI_BIT];
		cfg_now.drv = ms_r.slot[csp_pkg::DRV_BIT];
		cfg_now.ppe = ms_r.slot[csp_pkg::PPE_BIT];
		cfg_now.psel = ms_r.slot[csp_pkg::PSEL_BIT];
		cfg_now.ldly = {ms_r.slot[csp_pkg::LDHI_BIT], ms_r.ldly};
		cfg_now.rdly = {ms_r.slot[csp_pkg::RDHI_BIT], ms_r.rdly};
		unique case (csp_pkg::csp_afmt_t'(ms_r.fmt[csp_pkg::FMT_LSB+:2]))
			csp_pkg::AF_RJ: cfg_now.mode = csp_pkg::MD_RJ;
			csp_pkg::AF_LJ: cfg_now.mode = csp_pkg::MD_LJ;
			csp_pkg::AF_I2S: cfg_now.mode = csp_pkg::MD_I2S;
			csp_pkg::AF_PCM: begin
				if (ms_r.slot[csp_pkg::TSEN_BIT]) begin
					cfg_now.mode = csp_pkg::MD_TSLOT;
				end else begin
					cfg_now.mode = ms_r.fmt[csp_pkg::POL_BIT] ? csp_pkg::MD_PCMB : csp_pkg::MD_PCMA;
				end
			end
		endcase
	end

	// Master clock domain: registers, crossings, bit clock divider
	always_comb begin
		ms_nxt = ms_r;
		fifo_pop = 1'b0;
		if (!RST_N) begin
			ms_nxt = MS_RST;
		end else if (CE) begin
			// Synchronisers from the link domain
			ms_nxt.cack1 = lp_r.cack;
			ms_nxt.cack2 = ms_r.cack1;
			ms_nxt.aack1 = lp_r.aack;
			ms_nxt.aack2 = ms_r.aack1;
			ms_nxt.rtog1 = lp_r.rtog;
			ms_nxt.rtog2 = ms_r.rtog1;
			ms_nxt.rtog3 = ms_r.rtog2;
			// Register writes
			if (REG_WR) begin
				case (REG_ADDR)
					csp_pkg::ADDR_FMT: ms_nxt.fmt = REG_WDATA;
					csp_pkg::ADDR_ROLE: ms_nxt.role = REG_WDATA;
					csp_pkg::ADDR_LDLY: ms_nxt.ldly = REG_WDATA;
					csp_pkg::ADDR_SLOT: ms_nxt.slot = REG_WDATA;
					csp_pkg::ADDR_RDLY: ms_nxt.rdly = REG_WDATA;
					default: ms_nxt.fmt = ms_r.fmt;
				endcase
			end
			// Register reads; unmapped indices read zero
			if (REG_RD) begin
				case (REG_ADDR)
					csp_pkg::ADDR_FMT: ms_nxt.rdata = ms_r.fmt;
					csp_pkg::ADDR_ROLE: ms_nxt.rdata = ms_r.role;
					csp_pkg::ADDR_LDLY: ms_nxt.rdata = ms_r.ldly;
					csp_pkg::ADDR_SLOT: ms_nxt.rdata = ms_r.slot;
					csp_pkg::ADDR_RDLY: ms_nxt.rdata = ms_r.rdly;
					default: ms_nxt.rdata = '0;
				endcase
			end
			// Send a changed configuration once the last one is acknowledged
			if ((ms_r.creq == ms_r.cack2) && (cfg_now != ms_r.cfg_sent)) begin
				ms_nxt.cfg_sent = cfg_now;
				ms_nxt.creq = ~ms_r.creq;
			end
			// Offer the next ADC pair once the link took the last
			if ((ms_r.areq == ms_r.aack2) && fifo_vld) begin
				ms_nxt.adc_hold = csp_pkg::csp_pair_t'(fifo_dat);
				ms_nxt.areq = ~ms_r.areq;
				fifo_pop = 1'b1;
			end
			// New DAC pair wins over a consumer taking the old one
			if (ms_r.rtog2 != ms_r.rtog3) begin
				ms_nxt.dac = lp_r.rx_hold;
				ms_nxt.dac_vld = 1'b1;
			end else if (DAC_READY) begin
				ms_nxt.dac_vld = 1'b0;
			end
			// Bit clock divider runs only in master role
			if (ms_r.role[csp_pkg::ROLE_BIT]) begin
				if (ms_r.bdiv == BDIV_LAST) begin
					ms_nxt.bdiv = '0;
					ms_nxt.bclk = ~ms_r.bclk;
				end else begin
					ms_nxt.bdiv = ms_r.bdiv + 3'h1;
				end
			end else begin
				ms_nxt.bdiv = '0;
				ms_nxt.bclk = 1'b0;
			end
		end
	end

	// Master domain register
	always_ff @(posedge MCLK) begin
		ms_r <= ms_nxt;
	end

	// Link rising edge: positions, capture, next bit choice
	always_comb begin
		csp_pkg::csp_slot_t cur;
		csp_pkg::csp_slot_t nx;
		csp_pkg::csp_pair_t word;
		logic [10:0] nq;
		logic bound;
		logic last;
		logic nfs;
		logic fstart;
		cur = '0;
		nx = '0;
		word = lp_r.tx;
		nq = '0;
		bound = 1'b0;
		last = 1'b0;
		nfs = 1'b0;
		fstart = 1'b0;
		lp_nxt = lp_r;
		if (!lp_r.rst) begin
			lp_nxt = LP_RST;
		end else if (lp_r.ce) begin
			lp_nxt.creq1 = ms_r.creq;
			lp_nxt.creq2 = lp_r.creq1;
			lp_nxt.areq1 = ms_r.areq;
			lp_nxt.areq2 = lp_r.areq1;
			// Take a new configuration
			if (lp_r.creq2 != lp_r.cack) begin
				lp_nxt.cfg = ms_r.cfg_sent;
				lp_nxt.cack = lp_r.creq2;
			end
			// Boundaries come from sampled sync edges only
			if (is_frame(lp_r.cfg.mode)) begin
				bound = FRAME_SYNC_I && !lp_r.fs_prev;
			end else begin
				bound = FRAME_SYNC_I ^ lp_r.fs_prev;
			end
			lp_nxt.fs_prev = FRAME_SYNC_I;
			if (bound) begin
				lp_nxt.pos = 11'h001;
				lp_nxt.len = lp_r.pos;
			end else if (lp_r.pos != '1) begin
				lp_nxt.pos = lp_r.pos + 11'h001;
			end
			// Capture DAC data on this rising edge, MSB first
			cur = slot_at(lp_nxt.pos, lp_nxt.len, FRAME_SYNC_I, lp_r.cfg);
			if (cur.act) begin
				if (cur.right) begin
					lp_nxt.rx.right[TOPBIT-cur.idx] = DAC_SERIAL_IN;
				end else begin
					lp_nxt.rx.left[TOPBIT-cur.idx] = DAC_SERIAL_IN;
				end
				if (cur.right && (cur.idx == TOPBIT)) begin
					lp_nxt.rx_hold = lp_nxt.rx;
					lp_nxt.rtog = ~lp_r.rtog;
				end
			end
			// Predict the next edge from the measured length
			last = (lp_nxt.pos == lp_nxt.len);
			nq = last ? 11'h001 : lp_nxt.pos + 11'h001;
			nfs = (last && !is_frame(lp_r.cfg.mode)) ? ~FRAME_SYNC_I : FRAME_SYNC_I;
			fstart = last && (is_frame(lp_r.cfg.mode) || (nfs == (lp_r.cfg.mode != csp_pkg::MD_I2S)));
			if (fstart && (lp_r.areq2 != lp_r.aack)) begin
				word = ms_r.adc_hold;
				lp_nxt.tx = word;
				lp_nxt.aack = lp_r.areq2;
			end
			nx = slot_at(nq, lp_nxt.len, nfs, lp_r.cfg);
			lp_nxt.nact = nx.act;
			lp_nxt.nbit = nx.right ? word.right[TOPBIT-nx.idx] : word.left[TOPBIT-nx.idx];
			lp_nxt.hold = ln_r.oe;
		end
		// Reset and clock enable synchronisers
		lp_nxt.rst1 = RST_N;
		lp_nxt.rst = lp_r.rst1;
		lp_nxt.ce1 = CE;
		lp_nxt.ce = lp_r.ce1;
	end

	// Link rising edge register
	always_ff @(posedge BIT_CLK_I) begin
		lp_r <= lp_nxt;
	end

	// Link falling edge: launch data and master frame sync
	always_comb begin
		ln_nxt = ln_r;
		if (!lp_r.rst) begin
			ln_nxt = '0;
		end else if (lp_r.ce) begin
			ln_nxt.mcnt = (ln_r.mcnt == MLAST) ? '0 : ln_r.mcnt + 6'h01;
			if (is_frame(lp_r.cfg.mode)) begin
				ln_nxt.fs_o = (ln_r.mcnt == MLAST);
			end else begin
				ln_nxt.fs_o = (ln_r.mcnt < MHALF);
			end
			// Idle level follows the pull select
			ln_nxt.dout = lp_r.nact ? lp_r.nbit : lp_r.cfg.psel;
			ln_nxt.oe = lp_r.nact;
		end
	end

	// Link falling edge register
	always_ff @(negedge BIT_CLK_I) begin
		ln_r <= ln_nxt;
	end

	// Pin drivers
	assign BIT_CLK_O = ms_r.bclk;
	assign BIT_CLK_OE = ms_r.role[csp_pkg::ROLE_BIT];
	assign FRAME_SYNC_O = ln_r.fs_o;
	assign FRAME_SYNC_OE = lp_r.cfg.master;
	assign ADC_SERIAL_OUT_O = ln_r.dout;
	// Always driven, or driven only around data with selectable release
	assign ADC_SERIAL_OUT_OE = lp_r.cfg.drv | ln_r.oe | (~lp_r.cfg.tri_neg & lp_r.hold);
	assign ADC_PULL_UP = ~lp_r.cfg.drv & lp_r.cfg.ppe & lp_r.cfg.psel;
	assign ADC_PULL_DOWN = ~lp_r.cfg.drv & lp_r.cfg.ppe & ~lp_r.cfg.psel;
	assign REG_RDATA = ms_r.rdata;
	assign DAC_DATA = ms_r.dac;
	assign DAC_VALID = ms_r.dac_vld;
endmodule

// file: inc/csp_pkg.sv
// Shared constants and types of the codec audio serial port.
package csp_pkg;
	// Register indices on the control port
	localparam logic [6:0] ADDR_FMT = 7'h04;
	localparam logic [6:0] ADDR_ROLE = 7'h06;
	localparam logic [6:0] ADDR_LDLY = 7'h3b;
	localparam logic [6:0] ADDR_SLOT = 7'h3c;
	localparam logic [6:0] ADDR_RDLY = 7'h3d;
	// Field positions
	localparam int FMT_LSB = 3;
	localparam int POL_BIT = 7;
	localparam int ROLE_BIT = 0;
	localparam int TSEN_BIT = 8;
	localparam int TRI_BIT = 7;
	localparam int DRV_BIT = 5;
	localparam int PPE_BIT = 4;
	localparam int PSEL_BIT = 3;
	localparam int LDHI_BIT = 1;
	localparam int RDHI_BIT = 0;
	// Reset values
	localparam logic [8:0] FMT_RST = 9'h010;
	localparam logic [8:0] ROLE_RST = 9'h000;
	localparam logic [8:0] DLY_RST = 9'h000;
	localparam logic [8:0] SLOT_RST = 9'h020;
	// Sizes
	localparam int SAMPLE_W = 24;
	localparam int FIFO_DEPTH = 4;
	localparam int MASTER_HALF = 32;
	// Timing: least bit clock period, halved, in master clock cycles
	localparam int MCLK_PERIOD_NS = 8;
	localparam int BCLK_MIN_NS = 50;
	localparam int BCLK_HALF_CYC = (BCLK_MIN_NS + 2 * MCLK_PERIOD_NS - 1) / (2 * MCLK_PERIOD_NS);
	// Format field codes
	typedef enum logic [1:0] {
		AF_RJ = 2'h0,
		AF_LJ = 2'h1,
		AF_I2S = 2'h2,
		AF_PCM = 2'h3
	} csp_afmt_t;
	// Resolved framing modes
	typedef enum logic [2:0] {
		MD_RJ = 3'h0,
		MD_LJ = 3'h1,
		MD_I2S = 3'h2,
		MD_PCMA = 3'h3,
		MD_PCMB = 3'h4,
		MD_TSLOT = 3'h5
	} csp_mode_t;
	// One stereo sample pair
	typedef struct packed {
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
	} csp_pair_t;
	// Configuration seen by the link logic
	typedef struct packed {
		csp_mode_t mode;
		logic master;
		logic tri_neg;
		logic drv;
		logic ppe;
		logic psel;
		logic [9:0] ldly;
		logic [9:0] rdly;
	} csp_cfg_t;
	// Decoded slot of one bit clock edge
	typedef struct packed {
		logic act;
		logic right;
		logic [4:0] idx;
	} csp_slot_t;
	localparam csp_cfg_t CFG_RST = '{mode: MD_I2S, master: 1'b0, tri_neg: 1'b0, drv: 1'b1,
		ppe: 1'b0, psel: 1'b0, ldly: 10'h000, rdly: 10'h000};
endpackage

// file: verification/csp_port_props.sv
// Concurrent checks on the serial port top.
`timescale 1ns/100ps
module csp_port_props (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [6:0] REG_ADDR,
	input wire logic [8:0] REG_WDATA,
	input wire logic [8:0] REG_RDATA,
	input wire logic DAC_VALID,
	input wire logic DAC_READY,
	input wire logic BIT_CLK_I,
	input wire logic BIT_CLK_O,
	input wire logic BIT_CLK_OE,
	input wire logic FRAME_SYNC_O,
	input wire logic FRAME_SYNC_OE,
	input wire logic ADC_SERIAL_OUT_OE,
	input wire logic ADC_PULL_UP,
	input wire logic ADC_PULL_DOWN
);
	logic [8:0] slot_r; // Shadow of the slot output register
	logic [5:0] age_r; // Cycles since the last write, saturating
	// Settled configuration tracker
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			slot_r <= csp_pkg::SLOT_RST;
			age_r <= 6'h00;
		end else if (REG_WR && CE) begin
			age_r <= 6'h00;
			if (REG_ADDR == csp_pkg::ADDR_SLOT) begin
				slot_r <= REG_WDATA;
			end
		end else if (age_r != 6'h3f) begin
			age_r <= age_r + 6'h01;
		end
	end
	role_oe_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		REG_WR && CE && REG_ADDR == csp_pkg::ADDR_ROLE |=> BIT_CLK_OE == $past(REG_WDATA[0])) else $error("role bit not applied");
	reset_slave_a: assert property (@(posedge MCLK)
		!RST_N |=> !BIT_CLK_OE && REG_RDATA == 9'h000) else $error("reset not in slave role");
	bclk_div_a: assert property (@(posedge MCLK) disable iff (!RST_N || !BIT_CLK_OE)
		$rose(BIT_CLK_O) |-> BIT_CLK_O [*4] ##1 !BIT_CLK_O) else $error("bit clock high time wrong");
	fs_half_a: assert property (@(posedge BIT_CLK_I) disable iff (!RST_N || !FRAME_SYNC_OE)
		$fell(FRAME_SYNC_O) |-> ##32 $rose(FRAME_SYNC_O)) else $error("sync half length wrong");
	drive_on_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		age_r == 6'h3f && slot_r[5] |-> ADC_SERIAL_OUT_OE) else $error("output released while driven");
	pull_sel_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		age_r == 6'h3f && !slot_r[5] && slot_r[4] |-> ADC_PULL_UP == slot_r[3] && ADC_PULL_DOWN != slot_r[3])
		else $error("pull level wrong");
	rdata_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		$changed(REG_RDATA) |-> $past(REG_RD) || !$past(RST_N)) else $error("read data moved");
	unmapped_rd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		REG_RD && CE && REG_ADDR == 7'h10 |=> REG_RDATA == 9'h000) else $error("unmapped read not zero");
	dac_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		DAC_VALID && !DAC_READY |=> DAC_VALID) else $error("dac pair dropped");
endmodule
bind csp_port csp_port_props u_props (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .DAC_VALID(DAC_VALID),
	.DAC_READY(DAC_READY), .BIT_CLK_I(BIT_CLK_I), .BIT_CLK_O(BIT_CLK_O), .BIT_CLK_OE(BIT_CLK_OE),
	.FRAME_SYNC_O(FRAME_SYNC_O), .FRAME_SYNC_OE(FRAME_SYNC_OE), .ADC_SERIAL_OUT_OE(ADC_SERIAL_OUT_OE),
	.ADC_PULL_UP(ADC_PULL_UP), .ADC_PULL_DOWN(ADC_PULL_DOWN));

// file: verification/csp_host.sv
// Host serial port model: bit clock, frame sync and DAC data out, ADC data in.
`timescale 1ns/100ps
module csp_host (
	output logic bclk,
	output logic fs,
	output logic sdo,
	input wire logic sdi,
	input wire csp_pkg::csp_mode_t mode,
	input wire logic [9:0] ldly,
	input wire logic [9:0] rdly,
	input wire csp_pkg::csp_pair_t tx,
	output csp_pkg::csp_pair_t rx,
	output int frames,
	output int p
);
	int lp; // Left MSB edge in the frame
	int rp; // Right MSB edge in the frame
	csp_pkg::csp_pair_t sh; // Capture store
	// MSB edges of each framing
	assign lp = mode == csp_pkg::MD_RJ ? 9 : mode == csp_pkg::MD_LJ ? 1 : mode == csp_pkg::MD_PCMB ? 1 :
		mode == csp_pkg::MD_TSLOT ? int'(ldly) + 1 : 2;
	assign rp = mode == csp_pkg::MD_TSLOT ? int'(rdly) + 1 : mode >= csp_pkg::MD_PCMA ? lp + 24 : lp + 32;
	// Free running bit clock, phase unrelated to the master clock
	initial begin
		bclk = 1'b0;
		fs = 1'b0;
		sdo = 1'b0;
		p = 0;
		frames = 0;
		sh = '0;
		rx = '0;
		#3.3;
		forever #7.5 bclk = ~bclk;
	end
	// Launch sync and data ahead of the next rising edge
	always @(negedge bclk) begin
		p = p % 64 + 1;
		fs = mode >= csp_pkg::MD_PCMA ? p == 1 : (mode == csp_pkg::MD_I2S) ^ (p <= 32);
		if (p >= lp && p < lp + 24) begin
			sdo = tx.left[23 - (p - lp)];
		end else if (p >= rp && p < rp + 24) begin
			sdo = tx.right[23 - (p - rp)];
		end else begin
			sdo = ~sdo;
		end
	end
	// Sample ADC data on rising edges
	always @(posedge bclk) begin
		if (p >= lp && p < lp + 24) begin
			sh.left[23 - (p - lp)] = sdi;
		end
		if (p >= rp && p < rp + 24) begin
			sh.right[23 - (p - rp)] = sdi;
		end
		if (p == 64) begin
			rx = sh;
			frames++;
		end
	end
endmodule

// file: verification/csp_port_tb.sv
// Self-checking bench of the serial port: registers, roles, framings, pin modes and sample FIFO.
`timescale 1ns/100ps
module csp_port_tb;
	localparam logic [8:0] FMTS [6] = '{9'h000, 9'h008, 9'h010, 9'h018, 9'h098, 9'h098};
	logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, adc_valid = 1'b0, dac_ready = 1'b1;
	logic [6:0] reg_addr = 7'h00;
	logic [8:0] reg_wdata = 9'h000, reg_rdata;
	csp_pkg::csp_pair_t adc_data = '0, dac_data, dac_seen = '0, tx = '0, rx;
	csp_pkg::csp_mode_t mode = csp_pkg::MD_I2S; // Host framing
	logic adc_ready, dac_valid, bclk_o, bclk_oe, fs_o, fs_oe, adc_o, adc_oe, pull_up, pull_dn;
	logic h_bclk, h_fs, h_sdo, flt_r = 1'b0;
	int frames, hp, errors = 0, total_checks = 0, cyc = 0;
	// Resolved pins: the driving party wins, a released line without a pull wanders
	wire bclk_w = bclk_oe ? bclk_o : h_bclk;
	wire fs_w = fs_oe ? fs_o : h_fs;
	wire adc_w = adc_oe ? adc_o : pull_up ? 1'b1 : pull_dn ? 1'b0 : flt_r;
	csp_port u_dut (.MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .ADC_VALID(adc_valid), .ADC_READY(adc_ready),
		.ADC_DATA(adc_data), .DAC_VALID(dac_valid), .DAC_READY(dac_ready), .DAC_DATA(dac_data),
		.BIT_CLK_I(bclk_w), .BIT_CLK_O(bclk_o), .BIT_CLK_OE(bclk_oe), .FRAME_SYNC_I(fs_w), .FRAME_SYNC_O(fs_o),
		.FRAME_SYNC_OE(fs_oe), .DAC_SERIAL_IN(h_sdo), .ADC_SERIAL_OUT_O(adc_o), .ADC_SERIAL_OUT_OE(adc_oe),
		.ADC_PULL_UP(pull_up), .ADC_PULL_DOWN(pull_dn));
	csp_host u_host (.bclk(h_bclk), .fs(h_fs), .sdo(h_sdo), .sdi(adc_w), .mode(mode), .ldly(10'h003),
		.rdly(10'h01e), .tx(tx), .rx(rx), .frames(frames), .p(hp));
	// Master clock
	initial begin
		forever #4 mclk = ~mclk;
	end
	// Floating line, DAC capture and hang guard
	always @(posedge mclk) begin
		flt_r <= ~flt_r;
		if (dac_valid && dac_ready) begin
			dac_seen <= dac_data;
		end
		cyc++;
		if (cyc == 20000) begin
			errors++;
			$display("[FAIL] %0t timeout", $time);
			final_report;
		end
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [6:0] a, input logic [8:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		chk(48'(reg_rdata), 48'(e));
	endtask
	// Wait for whole host frames
	task automatic wf(input int n);
		int f;
		f = frames + n;
		while (frames < f) @(posedge mclk);
	endtask
	task automatic push(input csp_pkg::csp_pair_t d);
		adc_data <= d;
		adc_valid <= 1'b1;
		@(posedge mclk);
		while (!adc_ready) @(posedge mclk);
		adc_valid <= 1'b0;
		@(posedge mclk);
	endtask
	// Reset values, unmapped index, read back
	task automatic t_regs;
		rd(csp_pkg::ADDR_FMT, csp_pkg::FMT_RST);
		rd(csp_pkg::ADDR_ROLE, csp_pkg::ROLE_RST);
		rd(csp_pkg::ADDR_SLOT, csp_pkg::SLOT_RST);
		rd(csp_pkg::ADDR_LDLY, csp_pkg::DLY_RST);
		rd(csp_pkg::ADDR_RDLY, csp_pkg::DLY_RST);
		wr(7'h10, 9'h1ff);
		rd(7'h10, 9'h000);
		wr(csp_pkg::ADDR_LDLY, 9'h003);
		wr(csp_pkg::ADDR_RDLY, 9'h01e);
		rd(csp_pkg::ADDR_LDLY, 9'h003);
		rd(csp_pkg::ADDR_RDLY, 9'h01e);
		chk(48'({bclk_oe, fs_oe}), 48'h0);
	endtask
	// Master role on, then back to slave
	task automatic t_master;
		wr(csp_pkg::ADDR_ROLE, 9'h001);
		repeat (1200) @(posedge mclk);
		chk(48'({bclk_oe, fs_oe}), 48'h3);
		wr(csp_pkg::ADDR_ROLE, 9'h000);
		repeat (300) @(posedge mclk);
		chk(48'({bclk_oe, fs_oe}), 48'h0);
	endtask
	// Every framing, both directions, in slave role
	task automatic t_formats;
		csp_pkg::csp_pair_t d;
		for (int i = 0; i < 6; i++) begin
			tx = {24'h800001 ^ 24'(i), 24'h400003 + 24'(i)};
			d = {24'h900005 + 24'(i), 24'h0a0c07 ^ 24'(i << 4)};
			mode = csp_pkg::csp_mode_t'(i);
			wr(csp_pkg::ADDR_FMT, FMTS[i]);
			wr(csp_pkg::ADDR_SLOT, i == 5 ? 9'h120 : 9'h020);
			wf(4);
			push(d);
			wf(3);
			chk(rx, d);
			chk(dac_seen, tx);
		end
	endtask
	// Idle pin level and enable in slot mode
	task automatic t_pins;
		logic [8:0] s [4] = '{9'h120, 9'h128, 9'h118, 9'h100};
		for (int i = 0; i < 4; i++) begin
			wr(csp_pkg::ADDR_SLOT, s[i]);
			wf(2);
			while (hp != 60) @(posedge mclk);
			if (i < 3) chk(48'(adc_w), 48'(i != 0));
			chk(48'(adc_oe), 48'(i < 2));
		end
		wr(csp_pkg::ADDR_SLOT, 9'h120);
	endtask
	// Fill the FIFO until refused with the DAC side stalled, then drain
	task automatic t_fifo;
		int n;
		n = 0;
		dac_ready <= 1'b0;
		adc_valid <= 1'b1;
		repeat (8) begin
			adc_data <= {24'(n), 24'hc00000 | 24'(n)};
			@(posedge mclk);
			if (adc_ready) n++;
		end
		adc_valid <= 1'b0;
		chk(48'(n < 8 && n >= csp_pkg::FIFO_DEPTH), 48'h1);
		wf(8);
		chk(48'(dac_valid), 48'h1);
		chk(48'(adc_ready), 48'h1);
		chk(rx, {24'(n - 1), 24'hc00000 | 24'(n - 1)});
		dac_ready <= 1'b1;
		@(posedge mclk);
	endtask
	task automatic final_report;
		if (errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_regs;
		t_master;
		t_formats;
		t_pins;
		t_fifo;
		final_report;
	end
endmodule
